// [design/colid_pkg.sv]
// shared constants for the overlay freeze and identify command block
package colid_pkg;
    // command opcode and subcommand feature codes
    localparam logic [7:0]  CMD_CONFIG        = 8'hB1;
    localparam logic [7:0]  FEAT_RESTORE      = 8'hC0;
    localparam logic [7:0]  FEAT_FREEZE       = 8'hC1;
    localparam logic [7:0]  FEAT_IDENTIFY     = 8'hC2;
    localparam logic [7:0]  FEAT_SET          = 8'hC3;
    // overlay structure layout
    localparam logic [15:0] OVL_REVISION      = 16'h0001;
    localparam logic [7:0]  OVL_SIGNATURE     = 8'hA5;
    localparam logic [7:0]  W_REV             = 8'h00;
    localparam logic [7:0]  W_MDMA            = 8'h01;
    localparam logic [7:0]  W_UDMA            = 8'h02;
    localparam logic [7:0]  W_LBA0            = 8'h03;
    localparam logic [7:0]  W_LBA3            = 8'h06;
    localparam logic [7:0]  W_FEAT            = 8'h07;
    localparam logic [7:0]  W_LAST            = 8'hFF;
    localparam int          MDMA_BITS         = 3;
    localparam int          UDMA_BITS         = 6;
    localparam int          FEAT_BITS         = 9;
    // register map, byte addresses
    localparam logic [7:0]  ADDR_CMD          = 8'h00;
    localparam logic [7:0]  ADDR_STATUS       = 8'h04;
    localparam logic [7:0]  ADDR_DATA         = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_STAT     = 8'h0C;
    localparam logic [7:0]  ADDR_IRQ_MASK     = 8'h10;
    localparam logic [7:0]  ADDR_CAP_DMA      = 8'h14;
    localparam logic [7:0]  ADDR_CAP_FEAT     = 8'h18;
    localparam logic [7:0]  ADDR_MAXLBA_LO    = 8'h1C;
    localparam logic [7:0]  ADDR_MAXLBA_HI    = 8'h20;
    // interrupt status bits
    localparam int          IRQ_DONE          = 0;
    localparam int          IRQ_ABORT         = 1;
    localparam int          IRQ_DRQ           = 2;
    localparam int          IRQ_BITS          = 3;
    // reset values
    localparam logic [31:0] CAP_DMA_RST       = 32'h0000_0000;
    localparam logic [31:0] CAP_FEAT_RST      = 32'h0000_0000;
    localparam logic [31:0] MAXLBA_RST        = 32'h0000_0000;
    localparam logic [2:0]  IRQ_MASK_RST      = 3'h0;
endpackage

// [design/colid_word_rom.sv]
// combinational overlay structure word generator
`timescale 1ns/1ns
module colid_word_rom
(
    input  wire logic [7:0]  word_idx,
    input  wire logic [2:0]  mdma_cap,
    input  wire logic [5:0]  udma_cap,
    input  wire logic [47:0] max_lba,
    input  wire logic [8:0]  feat_cap,
    input  wire logic [7:0]  checksum,
    output logic      [15:0] word_val
);
    always_comb
    begin
        word_val = 16'h0000;
        case (word_idx)
            colid_pkg::W_REV:  word_val = colid_pkg::OVL_REVISION;
            colid_pkg::W_MDMA: word_val = {13'h0000, mdma_cap};
            colid_pkg::W_UDMA: word_val = {10'h000, udma_cap};
            8'h03:             word_val = max_lba[15:0];
            8'h04:             word_val = max_lba[31:16];
            8'h05:             word_val = max_lba[47:32];
            colid_pkg::W_LBA3: word_val = 16'h0000;
            colid_pkg::W_FEAT: word_val = {7'h00, feat_cap};
            colid_pkg::W_LAST: word_val = {checksum,
                                           colid_pkg::OVL_SIGNATURE};
            default:           word_val = 16'h0000;
        endcase
    end
endmodule // colid_word_rom

// [design/colid_cksum.sv]
// running byte sum of the overlay words and its two's complement
`timescale 1ns/1ns
module colid_cksum
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        clear,
    input  wire logic        add_en,
    input  wire logic [15:0] add_word,
    output logic      [7:0]  checksum
);
    logic [7:0] sum_q;
    logic [7:0] sum_d;
    logic [7:0] sig_sum;

    assign sum_d   = 8'(sum_q + add_word[7:0] + add_word[15:8]);
    assign sig_sum = 8'(sum_q + colid_pkg::OVL_SIGNATURE);
    assign checksum = 8'(8'h00 - sig_sum);

    always_ff @(posedge clk_sys)
    begin
        if (rst || clear)
            sum_q <= 8'h00;
        else if (add_en)
            sum_q <= sum_d;
    end
endmodule // colid_cksum

// [design/colid_core.sv]
// overlay freeze and identify command handler with ahb-lite registers
//
// Function
// - feature C1h freezes overlay settings
// - frozen lock aborts all overlay subcommands
// - only power-up clears the lock
// - hardware and software resets keep lock
// - feature C2h returns 512 bytes PIO-in
// - overlay identify reports full capability set
// - word 0 holds revision 0001h
// - word 1 bits 2-0 multiword DMA
// - multiword DMA matches identify word 63
// - word 2 bits 5-0 Ultra DMA
// - word 7 bit 8 48-bit addressing
// - word 7 bits 7-0 feature flags
// - words 3-6 factory maximum LBA
// - word 255 low byte A5h
// - word 255 high byte is checksum
`timescale 1ns/1ns
module colid_core
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        power_on_rst,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq
);
    typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_DRQ} colid_state_t;

    colid_state_t state_q;
    logic         frozen_q;
    logic         busy_q;
    logic         err_q;
    logic [7:0]   idx_q;
    logic [2:0]   irq_stat_q;
    logic [2:0]   irq_mask_q;
    logic [31:0]  cap_dma_q;
    logic [31:0]  cap_feat_q;
    logic [31:0]  maxlba_lo_q;
    logic [31:0]  maxlba_hi_q;
    logic         wr_ph_q;
    logic [7:0]   addr_ph_q;
    logic [31:0]  rdata_q;
    logic         irq_q;

    logic         req;
    logic         wr_en;
    logic         rd_en;
    logic         wr_cmd;
    logic         wr_stat;
    logic         wr_mask;
    logic         data_pop;
    logic [7:0]   cmd_op;
    logic [7:0]   cmd_feat;
    logic         is_cfg;
    logic         is_freeze;
    logic         is_ident;
    logic         is_other;
    logic         cmd_abort;
    logic [15:0]  rom_word;
    logic [7:0]   checksum;
    logic         fill_add;
    logic [2:0]   irq_set;
    logic [31:0]  rd_mux;
    logic [31:0]  status_word;
    logic [2:0]   irq_clr;
    logic         in_fill;
    logic         in_drq;
    logic         cfg_wr;
    logic         wr_cap_dma;
    logic         wr_cap_feat;
    logic         wr_lba_lo;
    logic         wr_lba_hi;
    logic         sel_status;
    logic         sel_data;
    logic         sel_irq_stat;
    logic         sel_irq_mask;
    logic         sel_cap_dma;
    logic         sel_cap_feat;
    logic         sel_lba_lo;
    logic         sel_lba_hi;

    // address phase capture and write decode
    assign req     = hsel && hready && htrans[1];
    assign wr_en   = wr_ph_q;
    assign wr_cmd  = wr_en && (addr_ph_q == colid_pkg::ADDR_CMD);
    assign wr_stat = wr_en && (addr_ph_q == colid_pkg::ADDR_IRQ_STAT);
    assign wr_mask = wr_en && (addr_ph_q == colid_pkg::ADDR_IRQ_MASK);
    assign irq_clr = wr_stat ? hwdata[2:0] : 3'h0;
    assign rd_en   = req && !hwrite;
    assign in_fill = (state_q == ST_FILL);
    assign in_drq  = (state_q == ST_DRQ);
    assign data_pop = rd_en && sel_data && in_drq;

    // capability writes are refused while a command runs
    assign cfg_wr      = wr_en && !busy_q;
    assign wr_cap_dma  = cfg_wr && (addr_ph_q == colid_pkg::ADDR_CAP_DMA);
    assign wr_cap_feat = cfg_wr && (addr_ph_q == colid_pkg::ADDR_CAP_FEAT);
    assign wr_lba_lo   = cfg_wr && (addr_ph_q == colid_pkg::ADDR_MAXLBA_LO);
    assign wr_lba_hi   = cfg_wr && (addr_ph_q == colid_pkg::ADDR_MAXLBA_HI);

    // read decode on the address-phase address
    assign sel_status   = (haddr == colid_pkg::ADDR_STATUS);
    assign sel_data     = (haddr == colid_pkg::ADDR_DATA);
    assign sel_irq_stat = (haddr == colid_pkg::ADDR_IRQ_STAT);
    assign sel_irq_mask = (haddr == colid_pkg::ADDR_IRQ_MASK);
    assign sel_cap_dma  = (haddr == colid_pkg::ADDR_CAP_DMA);
    assign sel_cap_feat = (haddr == colid_pkg::ADDR_CAP_FEAT);
    assign sel_lba_lo   = (haddr == colid_pkg::ADDR_MAXLBA_LO);
    assign sel_lba_hi   = (haddr == colid_pkg::ADDR_MAXLBA_HI);

    assign cmd_op   = hwdata[7:0];
    assign cmd_feat = hwdata[15:8];
    assign is_cfg    = wr_cmd && !busy_q
                       && (cmd_op == colid_pkg::CMD_CONFIG);
    assign is_freeze = is_cfg && (cmd_feat == colid_pkg::FEAT_FREEZE);
    assign is_ident  = is_cfg && (cmd_feat == colid_pkg::FEAT_IDENTIFY);
    assign is_other  = is_cfg && !is_freeze && !is_ident;
    assign cmd_abort = is_cfg && (frozen_q || is_other);

    assign fill_add = (state_q == ST_FILL) && (idx_q != colid_pkg::W_LAST);

    // full capability set from capability registers
    colid_word_rom u_rom
    (
        .word_idx (idx_q),
        .mdma_cap (cap_dma_q[2:0]),
        .udma_cap (cap_dma_q[13:8]),
        .max_lba  ({maxlba_hi_q[15:0], maxlba_lo_q}),
        .feat_cap (cap_feat_q[8:0]),
        .checksum (checksum),
        .word_val (rom_word)
    );

    colid_cksum u_cksum
    (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .clear    (is_ident),
        .add_en   (fill_add),
        .add_word (rom_word),
        .checksum (checksum)
    );

    // lock flag: power-on only
    always_ff @(posedge clk_sys)
    begin
        if (power_on_rst)
            frozen_q <= 1'b0;
        else if (is_freeze && !cmd_abort)
            frozen_q <= 1'b1;
    end

    // command sequencer: fill pass computes checksum, then drq streaming
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            idx_q   <= 8'h00;
            busy_q  <= 1'b0;
            err_q   <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (cmd_abort)
                        err_q <= 1'b1;
                    else if (is_freeze)
                        err_q <= 1'b0;
                    else if (is_ident)
                    begin
                        err_q   <= 1'b0;
                        busy_q  <= 1'b1;
                        idx_q   <= 8'h00;
                        state_q <= ST_FILL;
                    end
                end
                ST_FILL:
                begin
                    if (idx_q == colid_pkg::W_LAST)
                    begin
                        idx_q   <= 8'h00;
                        state_q <= ST_DRQ;
                    end
                    else
                        idx_q <= 8'(idx_q + 8'h01);
                end
                ST_DRQ:
                begin
                    if (data_pop)
                    begin
                        if (idx_q == colid_pkg::W_LAST)
                        begin
                            busy_q  <= 1'b0;
                            state_q <= ST_IDLE;
                        end
                        idx_q <= 8'(idx_q + 8'h01);
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // interrupt events
    assign irq_set[colid_pkg::IRQ_DONE]  = (is_freeze && !cmd_abort)
        || (data_pop && idx_q == colid_pkg::W_LAST);
    assign irq_set[colid_pkg::IRQ_ABORT] = cmd_abort && state_q == ST_IDLE;
    assign irq_set[colid_pkg::IRQ_DRQ]   = (state_q == ST_FILL)
        && (idx_q == colid_pkg::W_LAST);

    // interrupt status, mask and level output
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            irq_stat_q <= 3'h0;
            irq_mask_q <= colid_pkg::IRQ_MASK_RST;
            irq_q      <= 1'b0;
        end
        else
        begin
            // set wins over write-one clear
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
            if (wr_mask)
                irq_mask_q <= hwdata[2:0];
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // capability registers feeding the overlay words
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            cap_dma_q   <= colid_pkg::CAP_DMA_RST;
            cap_feat_q  <= colid_pkg::CAP_FEAT_RST;
            maxlba_lo_q <= colid_pkg::MAXLBA_RST;
            maxlba_hi_q <= colid_pkg::MAXLBA_RST;
        end
        else
        begin
            if (wr_cap_dma)
                cap_dma_q <= {18'h0_0000, hwdata[13:8], 5'h00, hwdata[2:0]};
            if (wr_cap_feat)
                cap_feat_q <= {23'h00_0000, hwdata[8:0]};
            if (wr_lba_lo)
                maxlba_lo_q <= hwdata;
            if (wr_lba_hi)
                maxlba_hi_q <= {16'h0000, hwdata[15:0]};
        end
    end

    // task file untouched, status word and done interrupt event report completion
    assign status_word = {26'h000_0000, frozen_q, in_drq, in_fill, err_q,
                          !busy_q, busy_q};

    assign rd_mux =
        sel_status   ? status_word :
        sel_data     ? (in_drq ? {16'h0000, rom_word} : 32'h0000_0000) :
        sel_irq_stat ? {29'h0, irq_stat_q} :
        sel_irq_mask ? {29'h0, irq_mask_q} :
        sel_cap_dma  ? cap_dma_q :
        sel_cap_feat ? cap_feat_q :
        sel_lba_lo   ? maxlba_lo_q :
        sel_lba_hi   ? maxlba_hi_q :
        32'h0000_0000;

    // ahb-lite slave: zero wait, always okay
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wr_ph_q   <= 1'b0;
            addr_ph_q <= 8'h00;
            rdata_q   <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            wr_ph_q   <= req && hwrite;
            addr_ph_q <= haddr;
            if (rd_en)
                rdata_q <= rd_mux;
        end
    end

    assign hrdata = rdata_q;
    assign irq    = irq_q;
endmodule // colid_core

// [test/colid_host.sv]
// host bus master model that issues overlay subcommands
`timescale 1ns/1ns
module colid_host
(
    input  wire logic        clk_sys,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic      [7:0]  haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata
);
    initial
    begin
        hsel   = 1'b0;
        haddr  = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize  = 3'b010;
        hwdata = 32'h0000_0000;
    end
    // one word transfer, entered just after a rising edge
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk_sys); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        haddr  <= ~a;
        hwdata <= w ? d : ~hwdata;
        do @(posedge clk_sys); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic cmd(input logic [7:0] f, output logic [31:0] q);
        xfer(colid_pkg::ADDR_CMD, 1'b1,
             {16'h0000, f, colid_pkg::CMD_CONFIG}, q);
    endtask
endmodule // colid_host

// [test/colid_chk.sv]
// bus-side checker for the overlay freeze and identify block
`timescale 1ns/1ns
module colid_chk
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        power_on_rst,
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        irq
);
    logic       rd_q, wr_q, c1_q;
    logic [7:0] a_q, idx_q, sum_q;
    logic [3:0] age_q;
    wire take   = hsel & hready & htrans[1];
    wire rd_dat = rd_q & (a_q == colid_pkg::ADDR_DATA);
    wire rd_sts = rd_q & (a_q == colid_pkg::ADDR_STATUS);
    wire wr_cmd = wr_q & (a_q == colid_pkg::ADDR_CMD);
    wire frz    = wr_cmd & (hwdata[15:0] ==
                  {colid_pkg::FEAT_FREEZE, colid_pkg::CMD_CONFIG});
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    always_ff @(posedge clk_sys)
    begin
        rd_q <= ~rst & take & ~hwrite;
        wr_q <= ~rst & take & hwrite;
        a_q  <= haddr;
        idx_q <= (rst | wr_cmd) ? 8'h00 : idx_q + {7'h00, rd_dat};
        if (rst | wr_cmd)
            sum_q <= 8'h00;
        else if (rd_dat)
            sum_q <= sum_q + hrdata[7:0] + hrdata[15:8];
    end
    // lock model ignores rst, only power-up clears it
    always_ff @(posedge clk_sys)
    begin
        c1_q  <= power_on_rst ? 1'b0 : (c1_q | frz);
        age_q <= (power_on_rst | frz) ? 4'h0 : age_q + {3'h0, ~&age_q};
    end
    a_bus_okay:
        assert property (hreadyout & ~hresp)
        else $error("bus answer not okay");
    a_lock_held:
        assert property (rd_sts & c1_q & (&age_q) |-> hrdata[5])
        else $error("lock lost");
    a_lock_clear:
        assert property (rd_sts & ~c1_q |-> ~hrdata[5])
        else $error("lock without freeze");
    a_rev_word:
        assert property (rd_dat && idx_q == 8'h00
            |-> hrdata[15:0] == colid_pkg::OVL_REVISION)
        else $error("bad revision word");
    a_mdma_resv:
        assert property (rd_dat && idx_q == 8'h01 |-> hrdata[15:3] == 13'h0)
        else $error("mdma reserved bits set");
    a_resv_words:
        assert property (rd_dat && idx_q > 8'h07 && idx_q < 8'hFF
            |-> hrdata[15:0] == 16'h0000)
        else $error("reserved word not zero");
    a_sig_byte:
        assert property (rd_dat && &idx_q
            |-> hrdata[7:0] == colid_pkg::OVL_SIGNATURE)
        else $error("bad signature");
    a_sum_zero:
        assert property (rd_dat && &idx_q
            |-> sum_q + hrdata[7:0] + hrdata[15:8] == 8'h00)
        else $error("bad checksum");
endmodule // colid_chk
bind colid_core colid_chk u_chk (.clk_sys(clk_sys), .rst(rst),
    .power_on_rst(power_on_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq));

// [test/config_overlay_lock_identify_tb_top.sv]
// self-checking bench for the overlay freeze and identify block
`timescale 1ns/1ns
module config_overlay_lock_identify_tb_top;
    logic        clk_sys, rst, power_on_rst;
    logic        hsel, hwrite, hreadyout, hresp, irq;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata;
    int          fails = 0;
    int          total_checks = 0;
    int          cyc = 0;
    colid_host host (.clk_sys(clk_sys), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));
    colid_core dut (.clk_sys(clk_sys), .rst(rst), .power_on_rst(power_on_rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic give_verdict;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails++;
            give_verdict;
        end
    end
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        host.xfer(a, 1'b1, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        host.xfer(a, 1'b0, 32'h0000_0000, q);
    endtask
    task automatic poll(input int b, input logic v, output logic [31:0] s);
        int n;
        n = 0;
        rd(colid_pkg::ADDR_STATUS, s);
        while (s[b] !== v && n < 700)
        begin
            rd(colid_pkg::ADDR_STATUS, s);
            n++;
        end
        chk("status wait", {31'h0, v}, {31'h0, s[b]});
    endtask
    task automatic issue(input logic [7:0] f, output logic [31:0] s);
        host.cmd(f, s);
        poll(0, 1'b0, s);
    endtask
    function automatic logic [15:0] exp_w(input int i);
        case (i)
            0: exp_w = colid_pkg::OVL_REVISION;
            1: exp_w = 16'h0005;
            2: exp_w = 16'h003F;
            3: exp_w = 16'hCDEF;
            4: exp_w = 16'h89AB;
            5: exp_w = 16'h4567;
            7: exp_w = 16'h01A5;
            default: exp_w = 16'h0000;
        endcase
    endfunction
    task automatic t_reset;
        logic [31:0] q;
        rd(colid_pkg::ADDR_CAP_DMA, q);
        chk("cap dma", colid_pkg::CAP_DMA_RST, q);
        rd(colid_pkg::ADDR_MAXLBA_LO, q);
        chk("max lba", colid_pkg::MAXLBA_RST, q);
        rd(colid_pkg::ADDR_IRQ_MASK, q);
        chk("irq mask", {29'h0, colid_pkg::IRQ_MASK_RST}, q);
        wr(8'h3C, 32'hFFFF_FFFF);
        rd(8'h3C, q);
        chk("unmapped", 32'h0000_0000, q);
        $display("done reset");
    endtask
    task automatic t_identify;
        logic [31:0] q;
        logic [15:0] e;
        logic [7:0]  sum;
        wr(colid_pkg::ADDR_CAP_DMA, 32'hFFFF_FF05);
        wr(colid_pkg::ADDR_CAP_FEAT, 32'hFFFF_F1A5);
        wr(colid_pkg::ADDR_MAXLBA_LO, 32'h89AB_CDEF);
        wr(colid_pkg::ADDR_MAXLBA_HI, 32'hFFFF_4567);
        wr(colid_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
        host.cmd(colid_pkg::FEAT_IDENTIFY, q);
        poll(4, 1'b1, q);
        chk("drq irq", 32'h0000_0001, {31'h0, irq});
        sum = 8'h00;
        for (int i = 0; i < 256; i++)
        begin
            rd(colid_pkg::ADDR_DATA, q);
            e = exp_w(i);
            if (i == 255)
                e = {8'h00 - sum - colid_pkg::OVL_SIGNATURE,
                     colid_pkg::OVL_SIGNATURE};
            sum = sum + e[7:0] + e[15:8];
            chk("word", {16'h0, e}, {16'h0, q[15:0]});
        end
        poll(0, 1'b0, q);
        rd(colid_pkg::ADDR_IRQ_STAT, q);
        chk("done event", 32'h0000_0005, q);
        wr(colid_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
        rd(colid_pkg::ADDR_IRQ_STAT, q);
        chk("events cleared", 32'h0000_0000, q);
        chk("irq low", 32'h0, {31'h0, irq});
        $display("done identify");
    endtask
    task automatic t_mask;
        logic [31:0] q;
        wr(colid_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
        issue(colid_pkg::FEAT_RESTORE, q);
        chk("abort err", 32'h0000_0004, q & 32'h0000_0004);
        chk("masked irq", 32'h0, {31'h0, irq});
        wr(colid_pkg::ADDR_IRQ_MASK, 32'h0000_0002);
        rd(colid_pkg::ADDR_IRQ_MASK, q);
        chk("mask", 32'h0000_0002, q);
        chk("unmasked irq", 32'h0000_0001, {31'h0, irq});
        wr(colid_pkg::ADDR_IRQ_STAT, 32'h0000_0002);
        rd(colid_pkg::ADDR_IRQ_STAT, q);
        chk("abort cleared", 32'h0000_0000, q);
        chk("cleared irq", 32'h0, {31'h0, irq});
        $display("done mask");
    endtask
    task automatic t_freeze;
        logic [31:0] q;
        logic [7:0]  f [4];
        f = '{colid_pkg::FEAT_RESTORE, colid_pkg::FEAT_FREEZE,
              colid_pkg::FEAT_IDENTIFY, colid_pkg::FEAT_SET};
        issue(colid_pkg::FEAT_FREEZE, q);
        chk("freeze", 32'h0000_0020, q & 32'h0000_0024);
        for (int i = 0; i < 4; i++)
        begin
            wr(colid_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
            issue(f[i], q);
            chk("locked abort", 32'h0000_0024, q & 32'h0000_0034);
            rd(colid_pkg::ADDR_IRQ_STAT, q);
            chk("abort event", 32'h0000_0002, q & 32'h0000_0006);
        end
        $display("done freeze");
    endtask
    task automatic t_resets;
        logic [31:0] q;
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd(colid_pkg::ADDR_STATUS, q);
        chk("lock kept", 32'h0000_0020, q & 32'h0000_0020);
        rst <= 1'b1;
        power_on_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        power_on_rst <= 1'b0;
        @(posedge clk_sys);
        rd(colid_pkg::ADDR_STATUS, q);
        chk("lock gone", 32'h0, q & 32'h0000_0020);
        issue(colid_pkg::FEAT_FREEZE, q);
        chk("relock", 32'h0000_0020, q & 32'h0000_0024);
        $display("done resets");
    endtask
    initial
    begin
        rst = 1'b1;
        power_on_rst = 1'b1;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        power_on_rst <= 1'b0;
        @(posedge clk_sys);
        t_reset;
        t_identify;
        t_mask;
        t_freeze;
        t_resets;
        give_verdict;
    end
endmodule // config_overlay_lock_identify_tb_top
